// ===== pulse_interval_capture_timer.sv
// capture timer channel 0 with prescaler, mode control and APB registers
`include "capture_timer_cfg.svh"
// Summary of operation
// RQ1: start trigger write clears the channel counter, or loads holding in count-down modes, and starts counting
// RQ2: valid input edge copies counter into holding register, then raises interrupt
// RQ3: after capture the counter restarts from zero for the next interval
// RQ4: software discards the first capture after start as incomplete
// RQ5: clock gate bit zero stops or supplies the timer clock
// RQ6: four-bit prescale field divides input clock by two to the field
// RQ7: stop register bit zero stops channel 0; writing zero does nothing
// RQ8: start and stop bits of channels 2 and 3 exist on 16-pin only
// RQ9: capture modes count up, interval, event and one-count modes count down
// RQ10: edge select picks falling, rising or both edges
// RQ11: trigger source picks software, valid edge, both edges or master
// RQ12: count clock select uses operation clock or valid pin edges
// RQ13: counter and holding are 16 bits; counter wraps to zero
module pulse_interval_capture_timer #(
    parameter bit SIXTEEN_PIN = 1'b0
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pulse input and master channel event
    input  wire logic        capture_input_pin,
    input  wire logic        master_trigger,
    // interrupt
    output logic             capture_done_irq
);

    logic                          clk_gate_ff;
    logic [7:0]                    prescale_ff;
    logic [7:0]                    mode_high_ff;
    logic [7:0]                    mode_low_ff;
    logic [`CHANNELS-1:0]          chan_en_ff;
    capture_timer_pkg::chan_state_t st_ff;
    capture_timer_pkg::chan_state_t nxt_st;
    logic                          armed_ff;
    logic [15:0]                   counter_ff;
    logic [15:0]                   holding_ff;
    logic [1:0]                    irq_stat_ff;
    logic [1:0]                    irq_mask_ff;
    logic [31:0]                   prdata_ff;
    logic                          pready_ff;
    logic                          pslverr_ff;
    logic                          irq_ff;

    logic [1:0]  op_tick;
    logic        pin_rise;
    logic        pin_fall;
    logic        valid_edge;
    logic        trig_edge;
    logic        begin_edge;
    logic        end_edge;
    logic        mck_tick;
    logic        count_tick;
    logic        count_down;
    logic        is_capture;
    logic        is_cap_one;
    logic        mode_legal;
    logic        running;
    logic        cap_trig;
    logic        cap_arm;
    logic        zero_tick;
    logic        one_restart;
    logic        start_pulse;
    logic        stop_pulse;
    logic        cap_evt;
    logic        ovf_evt;
    logic        setup;
    logic        access_ok;
    logic        wr;
    logic        mapped;
    logic [31:0] rd_value;
    capture_timer_pkg::op_mode_t  op_mode;
    capture_timer_pkg::edge_sel_t edge_sel;
    capture_timer_pkg::trig_src_t trig_src;

    clock_prescaler u_prescaler
    (
        .mclk (mclk),
        .nrst (nrst),
        .gate (clk_gate_ff),
        .sel  (prescale_ff),
        .tick (op_tick)
    );

    pin_edge_sync u_pin_sync
    (
        .mclk (mclk),
        .nrst (nrst),
        .pin  (capture_input_pin),
        .rise (pin_rise),
        .fall (pin_fall)
    );

    assign op_mode  = capture_timer_pkg::op_mode_t'(mode_low_ff[3:1]);
    assign edge_sel = capture_timer_pkg::edge_sel_t'(mode_low_ff[7:6]);
    assign trig_src = capture_timer_pkg::trig_src_t'(mode_high_ff[2:0]);

    always_comb
    begin
        case (edge_sel)
            capture_timer_pkg::EDGE_FALL: valid_edge = pin_fall; // RQ10
            capture_timer_pkg::EDGE_RISE: valid_edge = pin_rise; // RQ10
            default:                      valid_edge = pin_rise | pin_fall; // RQ10
        endcase
    end

    // width mode: first edge arms, opposite edge captures
    assign begin_edge = (edge_sel == capture_timer_pkg::EDGE_BOTH_HIGH) ? pin_rise : pin_fall;
    assign end_edge   = (edge_sel == capture_timer_pkg::EDGE_BOTH_HIGH) ? pin_fall : pin_rise;

    always_comb
    begin
        case (trig_src)
            capture_timer_pkg::TRIG_EDGE:   trig_edge = valid_edge; // RQ11
            capture_timer_pkg::TRIG_BOTH:   trig_edge = pin_rise | pin_fall; // RQ11
            capture_timer_pkg::TRIG_MASTER: trig_edge = master_trigger; // RQ11
            default:                        trig_edge = 1'b0; // RQ11
        endcase
    end

    assign mck_tick = op_tick[mode_high_ff[`BIT_OP_CLK_SEL]];
    // event counter mode always counts pin edges
    assign count_tick = clk_gate_ff &
                        ((mode_high_ff[`BIT_COUNT_CLK_SEL] ||
                          op_mode == capture_timer_pkg::MODE_EVENT) ? valid_edge
                                                                   : mck_tick); // RQ12

    assign is_capture = (op_mode == capture_timer_pkg::MODE_CAPTURE);
    assign is_cap_one = (op_mode == capture_timer_pkg::MODE_CAP_ONE);
    assign count_down = (op_mode == capture_timer_pkg::MODE_INTERVAL) ||
                        (op_mode == capture_timer_pkg::MODE_EVENT) ||
                        (op_mode == capture_timer_pkg::MODE_ONE_COUNT); // RQ9
    // prohibited mode codes leave the counter frozen
    assign mode_legal = is_capture | is_cap_one | count_down; // RQ9
    assign running    = clk_gate_ff & (st_ff == capture_timer_pkg::CH_RUN);

    assign cap_trig    = running & ((is_capture & trig_edge) |
                                    (is_cap_one & armed_ff & end_edge)); // RQ2
    assign cap_arm     = running & is_cap_one & ~armed_ff & begin_edge;
    assign zero_tick   = running & count_down & count_tick & (counter_ff == 16'h0000);
    assign one_restart = running & (op_mode == capture_timer_pkg::MODE_ONE_COUNT) &
                         mode_low_ff[`BIT_START_IRQ] & trig_edge;

    // apb decode: zero wait states, answer in the first access cycle
    assign setup     = psel & ~penable;
    assign access_ok = psel & penable & pready_ff & ~pslverr_ff;
    assign wr        = access_ok & pwrite;
    // only the gate and the status clear are writable while the gate is off
    assign start_pulse = wr & clk_gate_ff & (paddr == `OFS_START) & pwdata[0]; // RQ1
    assign stop_pulse  = wr & clk_gate_ff & (paddr == `OFS_STOP) & pwdata[0]; // RQ7

    always_comb
    begin
        mapped   = 1'b1;
        rd_value = 32'h0000_0000;
        case (paddr)
            `OFS_CLK_ENABLE:  rd_value[0]   = clk_gate_ff;
            `OFS_PRESCALE:    rd_value[7:0] = prescale_ff;
            `OFS_MODE_HIGH:   rd_value[7:0] = mode_high_ff;
            `OFS_MODE_LOW:    rd_value[7:0] = mode_low_ff;
            `OFS_START:       rd_value      = 32'h0000_0000;
            `OFS_STOP:        rd_value      = 32'h0000_0000;
            `OFS_COUNTER:     rd_value[15:0] = counter_ff;
            `OFS_HOLDING:     rd_value[15:0] = holding_ff;
            `OFS_IRQ_STATUS:  rd_value[1:0] = irq_stat_ff;
            `OFS_IRQ_MASK:    rd_value[1:0] = irq_mask_ff;
            `OFS_CHAN_ENABLE: rd_value[`CHANNELS-1:0] = chan_en_ff;
            default:          mapped        = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup)
                prdata_ff <= rd_value;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            clk_gate_ff <= 1'b0;
        else if (wr && paddr == `OFS_CLK_ENABLE)
            clk_gate_ff <= pwdata[`BIT_CLK_GATE]; // RQ5
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            prescale_ff  <= `RST_BYTE;
            mode_high_ff <= `RST_BYTE;
            mode_low_ff  <= `RST_BYTE;
            irq_mask_ff  <= `RST_IRQ_BITS;
        end
        else if (wr && clk_gate_ff)
        begin
            case (paddr)
                `OFS_PRESCALE:  prescale_ff  <= pwdata[7:0]; // RQ6
                `OFS_MODE_HIGH: mode_high_ff <= pwdata[7:0];
                `OFS_MODE_LOW:  mode_low_ff  <= pwdata[7:0];
                `OFS_IRQ_MASK:  irq_mask_ff  <= pwdata[1:0];
                default:        irq_mask_ff  <= irq_mask_ff;
            endcase
        end
    end

    // channel flags; only channel 0 has a counter
    for (genvar ch = 0; ch < `CHANNELS; ch++)
    begin : g_chan_en
        if (ch >= 2 && !SIXTEEN_PIN)
        begin : g_absent
            assign chan_en_ff[ch] = 1'b0; // RQ8
        end
        else if (ch == 0)
        begin : g_main
            assign chan_en_ff[ch] = (st_ff == capture_timer_pkg::CH_RUN);
        end
        else
        begin : g_flag
            logic en_ff;
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                    en_ff <= 1'b0;
                else if (wr && clk_gate_ff && paddr == `OFS_STOP && pwdata[ch])
                    en_ff <= 1'b0; // RQ8
                else if (wr && clk_gate_ff && paddr == `OFS_START && pwdata[ch])
                    en_ff <= 1'b1; // RQ8
            end
            assign chan_en_ff[ch] = en_ff;
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            capture_timer_pkg::CH_STOP:
            begin
                if (start_pulse && !stop_pulse)
                    nxt_st = capture_timer_pkg::CH_RUN; // RQ1
            end
            capture_timer_pkg::CH_RUN:
            begin
                if (stop_pulse)
                    nxt_st = capture_timer_pkg::CH_STOP; // RQ7
                else if (zero_tick && op_mode == capture_timer_pkg::MODE_ONE_COUNT)
                    nxt_st = capture_timer_pkg::CH_STOP;
            end
            default: nxt_st = capture_timer_pkg::CH_STOP;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= capture_timer_pkg::CH_STOP;
        else
            st_ff <= nxt_st;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            armed_ff <= 1'b0;
        else if (start_pulse || !is_cap_one || !running)
            armed_ff <= 1'b0;
        else if (cap_arm)
            armed_ff <= 1'b1;
        else if (cap_trig)
            armed_ff <= 1'b0;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            counter_ff <= `RST_WORD;
        else if (start_pulse)
            counter_ff <= count_down ? holding_ff : 16'h0000; // RQ1
        else if (running && mode_legal)
        begin
            if (cap_trig || cap_arm)
                counter_ff <= 16'h0000; // RQ3
            else if (one_restart)
                counter_ff <= holding_ff;
            else if (count_tick && count_down)
                counter_ff <= zero_tick ? holding_ff : counter_ff - 16'h0001; // RQ9
            else if (count_tick && (is_capture || armed_ff))
                counter_ff <= counter_ff + 16'h0001; // RQ13
        end
    end

    // capture wins over a software write
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            holding_ff <= `RST_WORD;
        else if (cap_trig)
            holding_ff <= counter_ff; // RQ2
        else if (wr && clk_gate_ff && paddr == `OFS_HOLDING)
            holding_ff <= pwdata[15:0]; // RQ13
    end

    // first capture measures from the start write
    assign cap_evt = cap_trig | zero_tick |
                     (start_pulse & mode_low_ff[`BIT_START_IRQ] &
                      (is_capture | (op_mode == capture_timer_pkg::MODE_INTERVAL))); // RQ2
    assign ovf_evt = running & (is_capture | armed_ff) & count_tick & ~cap_trig &
                     (counter_ff == 16'hffff); // RQ13

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_stat_ff <= `RST_IRQ_BITS;
        else
        begin
            irq_stat_ff[`BIT_IRQ_CAPTURE] <= cap_evt |
                (irq_stat_ff[`BIT_IRQ_CAPTURE] &
                 ~(wr && paddr == `OFS_IRQ_STATUS && pwdata[`BIT_IRQ_CAPTURE])); // RQ2
            irq_stat_ff[`BIT_IRQ_OVERFLOW] <= ovf_evt |
                (irq_stat_ff[`BIT_IRQ_OVERFLOW] &
                 ~(wr && paddr == `OFS_IRQ_STATUS && pwdata[`BIT_IRQ_OVERFLOW]));
        end
    end

    // irq trails the status bit by one cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign capture_done_irq = irq_ff;

endmodule : pulse_interval_capture_timer

// ===== capture_timer_cfg.svh
// register offsets, field positions and reset values of the capture timer
`ifndef CAPTURE_TIMER_CFG_SVH
`define CAPTURE_TIMER_CFG_SVH

`define OFS_CLK_ENABLE      8'h00
`define OFS_PRESCALE        8'h04
`define OFS_MODE_HIGH       8'h08
`define OFS_MODE_LOW        8'h0c
`define OFS_START           8'h10
`define OFS_STOP            8'h14
`define OFS_COUNTER         8'h18
`define OFS_HOLDING         8'h1c
`define OFS_IRQ_STATUS      8'h20
`define OFS_IRQ_MASK        8'h24
`define OFS_CHAN_ENABLE     8'h28

`define BIT_CLK_GATE        0
`define BIT_OP_CLK_SEL      7
`define BIT_COUNT_CLK_SEL   4
`define BIT_START_IRQ       0
`define BIT_IRQ_CAPTURE     0
`define BIT_IRQ_OVERFLOW    1

`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
`define RST_IRQ_BITS        2'h0

`define PRESCALE_BITS       15
`define CHANNELS            4

`endif

// ===== capture_timer_pkg.sv
// types shared by the capture timer modules
package capture_timer_pkg;

    typedef enum logic {
        CH_STOP = 1'b0,
        CH_RUN  = 1'b1
    } chan_state_t;

    typedef enum logic [2:0] {
        MODE_INTERVAL  = 3'b000,
        MODE_CAPTURE   = 3'b010,
        MODE_EVENT     = 3'b011,
        MODE_ONE_COUNT = 3'b100,
        MODE_CAP_ONE   = 3'b110
    } op_mode_t;

    typedef enum logic [1:0] {
        EDGE_FALL      = 2'b00,
        EDGE_RISE      = 2'b01,
        EDGE_BOTH_LOW  = 2'b10,
        EDGE_BOTH_HIGH = 2'b11
    } edge_sel_t;

    typedef enum logic [2:0] {
        TRIG_SOFTWARE = 3'b000,
        TRIG_EDGE     = 3'b001,
        TRIG_BOTH     = 3'b010,
        TRIG_MASTER   = 3'b100
    } trig_src_t;

endpackage : capture_timer_pkg

// ===== pin_edge_sync.sv
// two-stage synchroniser with rise and fall detection for the capture pin
module pin_edge_sync
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // pin side
    input  wire logic pin,
    // detected edges, one-cycle pulses
    output logic      rise,
    output logic      fall
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            rise <= sync_ff & ~last_ff;
            fall <= ~sync_ff & last_ff;
        end
    end

endmodule : pin_edge_sync

// ===== clock_prescaler.sv
// power-of-two prescaler giving two operation clock enables
`include "capture_timer_cfg.svh"
module clock_prescaler
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // control
    input  wire logic       gate,
    input  wire logic [7:0] sel,
    // operation clock enables, one-cycle pulses
    output logic      [1:0] tick
);

    logic [`PRESCALE_BITS-1:0] cnt_ff;

    // gate off resets phase so ticks align to gate-on
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= '0;
        else if (!gate)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + `PRESCALE_BITS'(1);
    end

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_clk
        logic [`PRESCALE_BITS-1:0] mask;
        // code 15 wraps the shift to zero, so the mask becomes all ones
        assign mask = (`PRESCALE_BITS'(1) << sel[gi*4 +: 4]) - `PRESCALE_BITS'(1);
        always_ff @(posedge mclk or negedge nrst)
        begin
            if (!nrst)
                tick[gi] <= 1'b0;
            else
                tick[gi] <= gate & ((cnt_ff & mask) == mask); // RQ6
        end
    end

endmodule : clock_prescaler

// ===== capture_timer_checker_properties.sv
// port-level assertions for the capture timer channel
`include "capture_timer_cfg.svh"
module capture_timer_checker #(
    parameter bit SIXTEEN_PIN = 1'b0
)
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        nrst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin, master event and interrupt
    input wire logic        capture_input_pin,
    input wire logic        master_trigger,
    input wire logic        capture_done_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    logic       gate_ff;
    logic       run_ff;
    logic [1:0] mask_ff;
    logic       pin_ff;
    logic [3:0] quiet_ff;
    logic       wr_done;

    assign wr_done = psel && penable && pready && pwrite;

    // software view of gate, mask and run
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_ff <= 1'b0;
            run_ff  <= 1'b0;
            mask_ff <= 2'h0;
        end
        else if (wr_done && paddr == `OFS_CLK_ENABLE)
            gate_ff <= pwdata[`BIT_CLK_GATE];
        else if (wr_done && gate_ff && paddr == `OFS_IRQ_MASK)
            mask_ff <= pwdata[1:0];
        else if (wr_done && gate_ff && paddr == `OFS_START && pwdata[0])
            run_ff <= 1'b1;
        else if (wr_done && gate_ff && paddr == `OFS_STOP && pwdata[0])
            run_ff <= 1'b0;
    end

    // pin edges in flight may set status after a clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_ff   <= 1'b0;
            quiet_ff <= 4'h0;
        end
        else
        begin
            pin_ff   <= capture_input_pin;
            quiet_ff <= (pin_ff != capture_input_pin) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_ready_in_access: assert property (s_setup |=> s_access ##1 !pready)
        else $error("pready not one cycle");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready without setup");
    a_err_unmapped: assert property (s_setup and !pwrite && paddr > `OFS_CHAN_ENABLE
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped read");
    a_err_mapped: assert property (pslverr |-> pready && paddr > `OFS_CHAN_ENABLE)
        else $error("error on mapped");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_mask_readback: assert property (s_access and !pwrite && paddr == `OFS_IRQ_MASK
        |-> prdata[1:0] == mask_ff)
        else $error("mask readback");
    a_run_readback: assert property (s_access and !pwrite && paddr == `OFS_CHAN_ENABLE
        && gate_ff |-> prdata[0] == run_ff)
        else $error("run state readback");
    a_narrow_variant: assert property (s_access and !pwrite && paddr == `OFS_CHAN_ENABLE
        |-> SIXTEEN_PIN || prdata[3:2] == 2'b00)
        else $error("upper channel flag");
    a_irq_masked: assert property (mask_ff == 2'h0 && $past(mask_ff) == 2'h0
        |-> !capture_done_irq)
        else $error("irq while masked");
    a_irq_cleared: assert property (wr_done && paddr == `OFS_IRQ_STATUS && pwdata[1:0] == 2'h3
        && quiet_ff > 4'h7 |=> ##1 !capture_done_irq)
        else $error("irq after clear");
endmodule : capture_timer_checker

bind pulse_interval_capture_timer capture_timer_checker #(.SIXTEEN_PIN(SIXTEEN_PIN)) i_checker (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .master_trigger(master_trigger),
    .capture_done_irq(capture_done_irq)
);

// ===== pulse_source.sv
// external pulse source driving the capture pin
module pulse_source
(
    // clock
    input  wire logic mclk,
    // pulse output
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'b0;

    // one rising edge per call, len cycles long
    task automatic pulse(input int len);
        pin <= 1'b1;
        repeat (4) @(posedge mclk);
        pin <= 1'b0;
        repeat (len - 4) @(posedge mclk);
    endtask : pulse
endmodule : pulse_source

// ===== tb.sv
// self-checking bench for the pulse interval capture timer
`include "capture_timer_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        capture_input_pin;
    logic        capture_done_irq;
    int          error_cnt;
    int          samples_checked;
    int          len_q[$];

    pulse_interval_capture_timer #(.SIXTEEN_PIN(1'b0)) i_dut (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(capture_input_pin), .master_trigger(1'b0),
        .capture_done_irq(capture_done_irq)
    );
    pulse_source i_src (.mclk(mclk), .pin(capture_input_pin));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 16) error_cnt++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, q & m, exp);
    endtask : rd_chk

    // wait for irq, read holding, clear status
    task automatic grab(output logic [31:0] q);
        logic e;
        int   n = 0;
        while (capture_done_irq !== 1'b1 && n < 32)
        begin
            @(posedge mclk);
            n++;
        end
        check("irq raised", {31'h0, capture_done_irq}, 32'h1);
        apb(1'b0, `OFS_HOLDING, 32'h0, q, e);
        wr(`OFS_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge mclk);
    endtask : grab

    task automatic step(input int len, output logic [31:0] q);
        fork
            i_src.pulse(len);
            grab(q);
        join
    endtask : step

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    initial
    begin
        logic [31:0] q;
        logic [31:0] c2;
        logic        e;
        int          len;
        int          k1;
        int          k2;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(38813));
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk("gate reset", `OFS_CLK_ENABLE, 32'hff, 32'h0);
        rd_chk("prescale reset", `OFS_PRESCALE, 32'hff, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        rd_chk("mask while gated", `OFS_IRQ_MASK, 32'h3, 32'h0);
        apb(1'b0, 8'h2c, 32'h0, q, e);
        check("unmapped error", {31'h0, e}, 32'h1);
        wr(`OFS_CLK_ENABLE, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h1);
        rd_chk("mask with clock", `OFS_IRQ_MASK, 32'h3, 32'h1);
        $display("test registers done");
        // pin edges as count clock, software trigger only
        for (int s = 0; s < 4; s++)
        begin
            wr(`OFS_MODE_LOW, 32'(s << 6) | 32'h04);
            wr(`OFS_MODE_HIGH, 32'h10);
            wr(`OFS_START, 32'h1);
            rd_chk("counter cleared", `OFS_COUNTER, 32'hffff, 32'h0);
            repeat (3) i_src.pulse(8 + $urandom_range(0, 4));
            repeat (4) @(posedge mclk);
            rd_chk("edge count", `OFS_COUNTER, 32'hffff, (s < 2) ? 32'h3 : 32'h6);
            rd_chk("no capture", `OFS_IRQ_STATUS, 32'h1, 32'h0);
        end
        $display("test edge counting done");
        wr(`OFS_START, 32'hf);
        rd_chk("upper channels", `OFS_CHAN_ENABLE, 32'hd, 32'h1);
        wr(`OFS_STOP, 32'he);
        rd_chk("stop with zero", `OFS_CHAN_ENABLE, 32'h1, 32'h1);
        wr(`OFS_STOP, 32'h1);
        rd_chk("stopped", `OFS_CHAN_ENABLE, 32'h1, 32'h0);
        i_src.pulse(8);
        repeat (4) @(posedge mclk);
        rd_chk("stop holds", `OFS_COUNTER, 32'hffff, 32'h0);
        $display("test stop done");
        wr(`OFS_MODE_HIGH, 32'h01);
        wr(`OFS_MODE_LOW, 32'h44);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_START, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            len = 40 + $urandom_range(0, 160);
            step(len, q);
            // first value after start dropped
            if (i > 0) check("interval", q, 32'(len_q.pop_front() - 1));
            len_q.push_back(len);
        end
        wr(`OFS_IRQ_MASK, 32'h0);
        i_src.pulse(40);
        rd_chk("masked status", `OFS_IRQ_STATUS, 32'h1, 32'h1);
        wr(`OFS_IRQ_STATUS, 32'h3);
        rd_chk("status cleared", `OFS_IRQ_STATUS, 32'h3, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        $display("test capture done");
        // divided clock phase unknown: compare interval differences
        for (int p = 1; p < 4; p++)
        begin
            wr(`OFS_PRESCALE, 32'(p));
            wr(`OFS_START, 32'h1);
            k1 = 40 + $urandom_range(0, 30);
            k2 = 40 + $urandom_range(0, 30);
            step(k1 << p, q);
            step(k2 << p, c2);
            step(50 << p, q);
            check("prescaled", q - c2, 32'(k2 - k1));
        end
        $display("test prescale done");
        conclude();
    end
endmodule : tb
